// ==== verilog/vsb_frontend_agc_lock_control.sv ====
// Front-end control of an 8-level VSB demodulator: sample capture,
// rate conversion, fine gain loop, lock reporting and acquisition FSM.
// Assumes an APB master on the core clock; sample clock and data pins
// are asynchronous and are sampled by the core clock.
// How it works
// - Ten-bit samples read as offset binary (default) or two's complement.
// - Phase accumulator resamples input samples to twice the symbol rate.
// - Gain level averages 64 samples, or 256 with length bit set.
// - Average compared with a signed four-bit programmable threshold.
// - Gain pin: above drives 1, below 0, equal released; invert swaps.
// - Gain output invert bit resets to 0, non-inverted polarity.
// - Gain loop reset bit clears the fine gain section.
// - Carrier invert bit flips the frequency shift direction.
// - Segment sync drives front-end lock pin, mirrored in status.
// - FSM starts in state 0, then acquisition, training, normal.
// - Losing segment sync lock drops lock pin, FSM back to 0.
// - Acquisition goes on to training only with error level between two limits.
// - Back-end decoder held in reset throughout acquisition.
// - Training holds until equalizer lock or a sync error; normal holds until a sync error.
// - Error high for 100 ms resets equalizer one symbol period.
// - Sync and equalizer locked: equalizer lock pin high, status 11.
// - Squared error of equalizer versus training readable as 16 bits.
// - Equalizer coefficients update once per symbol period.
// - Bypass bit routes samples around the co-channel filter.
// - Active-low asynchronous reset forces all control state.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module vsb_frontend_agc_lock_control
  import vsb_fe_pkg::*;
#(
  parameter int EQ_TIMEOUT = EQ_TIMEOUT_CYC // Error timeout in cycles
) (
  input  wire logic        i_core_clk,          // Core clock 20 MHz
  input  wire logic        i_rst_n,             // Async reset, active low
  input  wire logic        i_psel,              // APB select
  input  wire logic        i_penable,           // APB enable
  input  wire logic        i_pwrite,            // APB write
  input  wire logic [7:0]  i_paddr,             // APB byte address
  input  wire logic [31:0] i_pwdata,            // APB write data
  output logic      [31:0] o_prdata,            // APB read data
  output logic             o_pready,            // APB ready
  output logic             o_pslverr,           // APB error
  input  wire logic        i_sample_clock_in,   // Sample clock pin
  input  wire logic [9:0]  i_sample_in,         // Sample data pins
  output logic             o_sample_clock_out,  // Sample clock to ADC
  input  wire logic        i_vsb_valid,         // Valid VSB detected
  input  wire logic        i_seg_sync_lock,     // Segment sync found
  input  wire logic        i_loops_locked,      // Gain/timing/carrier ok
  input  wire logic        i_sync_err,          // Synchronisation error
  input  wire logic        i_train_valid,       // Training symbol valid
  input  wire logic [7:0]  i_train_sym,         // Training reference
  input  wire logic [7:0]  i_eq_sym,            // Equalizer output
  output logic [9:0]       o_conv_sample,       // Resampled, signed
  output logic             o_conv_valid,        // Resampled strobe
  output logic             o_symbol_en,         // Symbol period strobe
  output logic             o_coef_update,       // Coefficient update
  output logic             o_carrier_invert,    // Carrier shift flip
  output logic             o_cochannel_filter_bypass, // Filter bypass
  output logic             o_backend_reset,     // Back-end reset
  output logic             o_eq_reset,          // Equalizer reset
  output logic             o_gain_ctrl_out,     // Gain pin level
  output logic             o_gain_ctrl_oe_n,    // Gain pin enable, low
  output logic             o_frontend_lock_pin, // Front-end lock
  output logic             o_equalizer_lock_pin // Equalizer lock
);
  gain_if gif ();
  logic [CTRL_W-1:0] ctrl_q;
  logic [3:0]        thresh_q;
  logic [15:0]       mse_lo_q;
  logic [15:0]       mse_hi_q;
  logic              wr_en;
  logic              rd_setup;
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == ADDR_CTRL) || (a == ADDR_THRESH) ||
              (a == ADDR_MSE_LIM) || (a == ADDR_STATUS) ||
              (a == ADDR_EQ_ERR);
  endfunction
  // APB: ready is raised for the access phase, so no wait states
  assign rd_setup = i_psel && !i_penable;
  assign wr_en    = i_psel && i_penable && o_pready && i_pwrite;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= rd_setup;
      o_pslverr <= rd_setup && !reg_hit(i_paddr);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q   <= CTRL_RST;
      thresh_q <= THRESH_RST;
      mse_lo_q <= MSE_LO_RST;
      mse_hi_q <= MSE_HI_RST;
    end else if (wr_en) begin
      unique case (i_paddr)
        ADDR_CTRL:    ctrl_q   <= i_pwdata[CTRL_W-1:0];
        ADDR_THRESH:  thresh_q <= i_pwdata[3:0];
        ADDR_MSE_LIM: begin
          mse_lo_q <= i_pwdata[15:0];
          mse_hi_q <= i_pwdata[31:16];
        end
        default: ;
      endcase
    end
  end
  // Sample pins cross from the sample clock domain
  logic       sclk_s1_q;
  logic       sclk_s2_q;
  logic       sclk_s3_q;
  logic [9:0] sdat_s1_q;
  logic [9:0] sdat_s2_q;
  logic       samp_edge;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sdat_s1_q <= 10'h000;
      sdat_s2_q <= 10'h000;
    end else begin
      sclk_s1_q <= i_sample_clock_in;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdat_s1_q <= i_sample_in;
      sdat_s2_q <= sdat_s1_q;
    end
  end

  assign samp_edge = sclk_s2_q && !sclk_s3_q;
  // Sample clock out is a divided core clock; the board loops it back
  logic [2:0] sdiv_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sdiv_q             <= 3'h0;
      o_sample_clock_out <= 1'b0;
    end else if (sdiv_q == SCLK_HALF_CYC - 3'h1) begin
      sdiv_q             <= 3'h0;
      o_sample_clock_out <= !o_sample_clock_out;
    end else begin
      sdiv_q <= sdiv_q + 3'h1;
    end
  end

  // Offset binary becomes signed by flipping the top bit
  logic [9:0] samp_q;
  logic       samp_vld_q;
  logic [9:0] samp_s;
  logic [8:0] samp_mag;
  logic [8:0] samp_mag_q;
  // Most negative code has no 9-bit magnitude, so it saturates
  always_comb begin
    samp_s = ctrl_q[CTRL_FMT] ? sdat_s2_q
                              : {~sdat_s2_q[9], sdat_s2_q[8:0]};
    samp_mag = !samp_s[9] ? samp_s[8:0]
             : (samp_s[8:0] == 9'h000) ? 9'h1ff : 9'(~samp_s[8:0] + 9'h001);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_q     <= 10'h000;
      samp_vld_q <= 1'b0;
    end else begin
      samp_vld_q <= samp_edge;
      if (samp_edge) begin
        samp_q <= samp_s;
      end
    end
  end

  // Rate converter: emit a sample whenever the accumulator wraps
  logic [15:0] phase_q;
  logic [16:0] phase_sum;
  logic        sym_phase_q;

  assign phase_sum = {1'b0, phase_q} + {1'b0, RATE_INC};

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q       <= 16'h0000;
      sym_phase_q   <= 1'b0;
      o_conv_sample <= 10'h000;
      o_conv_valid  <= 1'b0;
      o_symbol_en   <= 1'b0;
    end else begin
      o_conv_valid <= 1'b0;
      o_symbol_en  <= 1'b0;
      if (samp_vld_q) begin
        phase_q <= phase_sum[15:0];
        if (phase_sum[16]) begin
          o_conv_sample <= samp_q;
          o_conv_valid  <= 1'b1;
          sym_phase_q   <= !sym_phase_q;
          o_symbol_en   <= sym_phase_q;
        end
      end
    end
  end

  // Fine gain loop
  assign gif.sample_en  = samp_vld_q;
  assign gif.sample_mag = samp_mag_q;
  assign gif.avg_long   = ctrl_q[CTRL_AVGLEN];
  assign gif.invert     = ctrl_q[CTRL_INV];
  assign gif.loop_reset = ctrl_q[CTRL_GRST];
  assign gif.threshold  = thresh_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_mag_q <= 9'h000;
    end else if (samp_edge) begin
      samp_mag_q <= samp_mag;
    end
  end

  fine_gain_loop u_gain (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .g          (gif.gain)
  );

  assign o_gain_ctrl_out  = gif.out_level;
  assign o_gain_ctrl_oe_n = gif.out_oe_n;

  // Squared error, smoothed by a first-order average
  logic signed [8:0]  err;
  logic        [17:0] sq;
  logic        [15:0] sq_sat;
  logic        [15:0] mse_q;
  logic signed [17:0] mse_step;

  always_comb begin
    err      = $signed({i_eq_sym[7], i_eq_sym})
             - $signed({i_train_sym[7], i_train_sym});
    sq       = 18'(err) * 18'(err);
    sq_sat   = (sq[17:16] != 2'b00) ? 16'hffff : sq[15:0];
    mse_step = ($signed({2'b00, sq_sat}) - $signed({2'b00, mse_q}))
               >>> MSE_SHIFT;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mse_q <= 16'h0000;
    end else if (i_train_valid && o_symbol_en) begin
      mse_q <= 16'($signed({2'b00, mse_q}) + mse_step);
    end
  end

  // Acquisition state machine
  acq_state_t st_q;
  logic       mse_in_win;
  logic       eq_locked;
  logic       lost;

  assign mse_in_win = (mse_q >= mse_lo_q) && (mse_q <= mse_hi_q);
  assign eq_locked  = (mse_q <= mse_lo_q);
  assign lost       = !i_seg_sync_lock || i_sync_err;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (i_vsb_valid) begin
            st_q <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (!i_seg_sync_lock) begin
            st_q <= ST_IDLE;
          end else if (i_loops_locked && mse_in_win) begin
            st_q <= ST_TRAIN;
          end
        end
        ST_TRAIN: begin
          if (lost) begin
            st_q <= ST_IDLE;
          end else if (eq_locked) begin
            st_q <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (lost) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Long excessive error resets the equalizer for one symbol period
  logic [31:0] err_cnt_q;
  logic        training;
  logic        eq_fire;

  assign training = (st_q == ST_TRAIN) || (st_q == ST_NORMAL);
  assign eq_fire  = training && (mse_q > mse_hi_q) && !o_eq_reset
                    && (err_cnt_q == 32'(EQ_TIMEOUT - 1));

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_cnt_q  <= 32'h00000000;
      o_eq_reset <= 1'b0;
    end else begin
      if (o_eq_reset && o_symbol_en) begin
        o_eq_reset <= 1'b0;
      end
      if (!training || mse_q <= mse_hi_q || o_eq_reset) begin
        err_cnt_q <= 32'h00000000;
      end else if (err_cnt_q == 32'(EQ_TIMEOUT - 1)) begin
        err_cnt_q  <= 32'h00000000;
        o_eq_reset <= 1'b1;
      end else begin
        err_cnt_q <= err_cnt_q + 32'h00000001;
      end
    end
  end

  // Pins, back-end reset and per-symbol coefficient strobe
  logic [1:0] lock_stat_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_frontend_lock_pin       <= 1'b0;
      o_equalizer_lock_pin      <= 1'b0;
      lock_stat_q               <= LOCK_NONE;
      o_backend_reset           <= 1'b1;
      o_coef_update             <= 1'b0;
      o_carrier_invert          <= 1'b0;
      o_cochannel_filter_bypass <= 1'b0;
    end else begin
      o_frontend_lock_pin  <= i_seg_sync_lock;
      o_equalizer_lock_pin <= (st_q == ST_NORMAL) && !lost;
      if ((st_q == ST_NORMAL) && !lost) begin
        lock_stat_q <= LOCK_BOTH;
      end else if (i_seg_sync_lock) begin
        lock_stat_q <= LOCK_FE;
      end else begin
        lock_stat_q <= LOCK_NONE;
      end
      o_backend_reset  <= (st_q == ST_IDLE) || (st_q == ST_ACQ);
      o_coef_update    <= training && o_symbol_en && !o_eq_reset
                          && !eq_fire;
      o_carrier_invert <= ctrl_q[CTRL_CRINV];
      o_cochannel_filter_bypass <= ctrl_q[CTRL_BYPASS];
    end
  end

  // Read data is prepared in the setup cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
    end else if (rd_setup) begin
      unique case (i_paddr)
        ADDR_CTRL:    o_prdata <= {26'h0000000, ctrl_q};
        ADDR_THRESH:  o_prdata <= {28'h0000000, thresh_q};
        ADDR_MSE_LIM: o_prdata <= {mse_hi_q, mse_lo_q};
        ADDR_STATUS:  o_prdata <= {26'h0000000, gif.out_oe_n,
                                   gif.out_level, st_q, lock_stat_q};
        ADDR_EQ_ERR:  o_prdata <= {16'h0000, mse_q};
        default:      o_prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // vsb_frontend_agc_lock_control

// ==== include/vsb_fe_pkg.sv ====
// Constants, register map and types of the VSB front-end control block.
// Assumes a 20 MHz core clock and an APB register port with 32-bit data.
package vsb_fe_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_THRESH  = 8'h04;
  localparam logic [7:0] ADDR_MSE_LIM = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_EQ_ERR  = 8'h10;

  localparam int CTRL_FMT    = 0;
  localparam int CTRL_AVGLEN = 1;
  localparam int CTRL_INV    = 2;
  localparam int CTRL_GRST   = 3;
  localparam int CTRL_CRINV  = 4;
  localparam int CTRL_BYPASS = 5;
  localparam int CTRL_W      = 6;

  localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h00;
  localparam logic [3:0]        THRESH_RST = 4'h0;
  localparam logic [15:0]       MSE_LO_RST = 16'h0400;
  localparam logic [15:0]       MSE_HI_RST = 16'h4000;

  localparam logic [1:0] LOCK_NONE = 2'b00;
  localparam logic [1:0] LOCK_FE   = 2'b01;
  localparam logic [1:0] LOCK_BOTH = 2'b11;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACQ    = 2'b01,
    ST_TRAIN  = 2'b10,
    ST_NORMAL = 2'b11
  } acq_state_t;

  localparam logic [7:0]  AVG_LAST_SHORT = 8'h3f;
  localparam logic [7:0]  AVG_LAST_LONG  = 8'hff;
  localparam logic [15:0] RATE_INC       = 16'h9910;
  localparam logic [2:0]  SCLK_HALF_CYC  = 3'h4;
  localparam int          MSE_SHIFT      = 4;

  localparam int CORE_CLK_KHZ      = 20000;
  localparam int EQ_ERR_TIMEOUT_MS = 100;
  localparam int EQ_TIMEOUT_CYC    = EQ_ERR_TIMEOUT_MS * CORE_CLK_KHZ;
endpackage

// ==== include/gain_if.sv ====
// Carrier between the front-end core and its fine gain loop.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
interface gain_if;
  logic       sample_en;
  logic [8:0] sample_mag;
  logic       avg_long;
  logic       invert;
  logic       loop_reset;
  logic [3:0] threshold;
  logic       out_level;
  logic       out_oe_n;
  modport core (output sample_en, sample_mag, avg_long, invert,
                output loop_reset, threshold,
                input  out_level, out_oe_n);
  modport gain (input  sample_en, sample_mag, avg_long, invert,
                input  loop_reset, threshold,
                output out_level, out_oe_n);
endinterface

// ==== verilog/fine_gain_loop.sv ====
// Fine gain loop: averages sample magnitude and drives the gain pin.
// Assumes sample_en pulses once per captured input sample.
`timescale 1ns/100ps
module fine_gain_loop
  import vsb_fe_pkg::*;
(
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_rst_n,    // Async reset, active low
  gain_if.gain      g           // Samples, controls, pin drive
);
  logic [7:0]  cnt_q;
  logic [16:0] sum_q;
  logic [16:0] total;
  logic [8:0]  avg;
  logic [7:0]  last;
  logic signed [3:0] lvl;
  logic signed [3:0] thr;

  always_comb begin
    total = sum_q + {8'h00, g.sample_mag};
    last  = g.avg_long ? AVG_LAST_LONG : AVG_LAST_SHORT;
    avg   = g.avg_long ? total[16:8] : total[14:6];
    lvl   = $signed({~avg[8], avg[7:5]});
    thr   = $signed(g.threshold);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      sum_q <= 17'h00000;
    end else if (g.loop_reset) begin
      cnt_q <= 8'h00;
      sum_q <= 17'h00000;
    end else if (g.sample_en) begin
      if (cnt_q == last) begin
        cnt_q <= 8'h00;
        sum_q <= 17'h00000;
      end else begin
        cnt_q <= cnt_q + 8'h01;
        sum_q <= total;
      end
    end
  end

  // Equal level releases the pin, otherwise drive the comparator result
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      g.out_level <= 1'b0;
      g.out_oe_n  <= 1'b1;
    end else if (g.loop_reset) begin
      g.out_level <= 1'b0;
      g.out_oe_n  <= 1'b1;
    end else if (g.sample_en && cnt_q == last) begin
      g.out_oe_n  <= (lvl == thr);
      g.out_level <= (lvl > thr) ^ g.invert;
    end
  end
endmodule // fine_gain_loop

// ==== sim/adc_model.sv ====
// External converter and tuner gain integrator for the front-end.
// Assumes the bench sets the code and feeds the block's clock back.
`timescale 1ns/100ps
module adc_model (
  input  wire logic       i_sclk_fb,   // Clock from the block
  input  wire logic       i_gain_out,  // Gain pin level
  input  wire logic       i_gain_oe_n, // Gain pin enable, low
  input  wire logic [9:0] i_code,      // Code to convert
  output logic            o_sclk,      // Sample clock, 400 ns
  output logic      [9:0] o_data,      // Sample data
  output int              o_charge     // Integrator state
);
  // The board loops the block's sample clock out back to its input
  assign o_sclk = i_sclk_fb;
  initial begin
    o_data = 10'h000;
    o_charge = 0;
  end
  // Data moves on the fall so it is settled at the rise
  always @(negedge o_sclk) o_data <= i_code;
  // A released pin leaves the integrator alone
  always @(posedge o_sclk) begin
    if (!i_gain_oe_n)
      o_charge <= o_charge + (i_gain_out ? 1 : -1);
  end
endmodule // adc_model

// ==== sim/vsb_fe_chk_assertions.sv ====
// Port-level checks of the VSB front-end control block.
// Assumes binding into the top module; one core clock domain.
`timescale 1ns/100ps
module vsb_fe_chk (
  input wire logic i_core_clk,           // Core clock
  input wire logic i_rst_n,              // Reset, active low
  input wire logic i_psel,               // APB select
  input wire logic i_penable,            // APB enable
  input wire logic o_pready,             // APB ready
  input wire logic o_pslverr,            // APB error
  input wire logic i_seg_sync_lock,      // Segment sync found
  input wire logic o_sample_clock_out,   // Clock to converter
  input wire logic o_symbol_en,          // Symbol strobe
  input wire logic o_coef_update,        // Coefficient update
  input wire logic o_backend_reset,      // Back-end reset
  input wire logic o_eq_reset,           // Equalizer reset
  input wire logic o_gain_ctrl_oe_n,     // Gain pin enable, low
  input wire logic o_frontend_lock_pin,  // Front-end lock
  input wire logic o_equalizer_lock_pin  // Equalizer lock
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  AST_READY_SETUP: assert property (
    i_psel && !i_penable |=> o_pready)
    else $error("No ready after setup");
  AST_READY_ONE: assert property (
    o_pready |=> !o_pready)
    else $error("Ready longer than one cycle");
  AST_ERR_READY: assert property (
    o_pslverr |-> o_pready)
    else $error("Error without ready");
  AST_RST_VALUES: assert property (
    $rose(i_rst_n) |-> o_backend_reset && o_gain_ctrl_oe_n
      && !o_frontend_lock_pin && !o_equalizer_lock_pin)
    else $error("Outputs not at reset values");
  AST_FE_LOCK_RISE: assert property (
    $rose(i_seg_sync_lock) |-> ##[1:4] o_frontend_lock_pin)
    else $error("Lock pin did not rise");
  AST_FE_LOCK_FALL: assert property (
    $fell(i_seg_sync_lock) |-> ##[1:4] !o_frontend_lock_pin)
    else $error("Lock pin did not fall");
  AST_EQLOCK_DROP: assert property (
    $fell(o_frontend_lock_pin) |-> ##[0:3] !o_equalizer_lock_pin)
    else $error("Equalizer lock outlived sync lock");
  AST_COEF_STATE: assert property (
    o_coef_update |-> !o_backend_reset && !o_eq_reset)
    else $error("Coefficient update in wrong state");
  AST_SYM_PULSE: assert property (
    o_symbol_en |=> !o_symbol_en)
    else $error("Symbol strobe too long");
  AST_EQ_RST_LEN: assert property (
    $rose(o_eq_reset) |-> ##[1:60] !o_eq_reset)
    else $error("Equalizer reset too long");
  AST_SCLK_DIV: assert property (
    $changed(o_sample_clock_out) |=> $stable(o_sample_clock_out)[*3]
      ##1 $changed(o_sample_clock_out))
    else $error("Sample clock out not divided by eight");
  cover property ($rose(o_eq_reset));
  cover property ($rose(o_equalizer_lock_pin));
  cover property (o_pslverr);
  cover property ($fell(o_gain_ctrl_oe_n));
endmodule // vsb_fe_chk

bind vsb_frontend_agc_lock_control vsb_fe_chk chk_u (
  .i_core_clk, .i_rst_n, .i_psel, .i_penable, .o_pready, .o_pslverr,
  .i_seg_sync_lock, .o_sample_clock_out, .o_symbol_en, .o_coef_update,
  .o_backend_reset, .o_eq_reset, .o_gain_ctrl_oe_n,
  .o_frontend_lock_pin, .o_equalizer_lock_pin);

// ==== sim/vsb_frontend_agc_lock_control_tb_top.sv ====
// Self-checking bench for the VSB front-end control block.
// Assumes the converter model loops the 400 ns sample clock back.
`timescale 1ns/100ps
`define CHK(a, b) check(32'(a), 32'(b))
module vsb_frontend_agc_lock_control_tb_top;
  import vsb_fe_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
  logic [7:0]  paddr = 8'h00, tsym = 8'h00, esym = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, sclk, sco, cv, se, cu, cinv, byp;
  logic        ber, eqr, gout, goe_n, fel, eql;
  logic        vsb = 1'b0, seg = 1'b0, lkd = 1'b0, serr = 1'b0;
  logic        tv = 1'b0;
  logic [9:0]  code = 10'h200, sdata, csamp;
  int          charge, fails = 0, comparisons = 0;
  // Entry: format, invert, threshold, code, oe_n, level
  localparam logic [17:0] GTAB [7] = '{
    {2'b00, 4'h0, 10'h200, 2'b00}, {2'b00, 4'h0, 10'h3ff, 2'b01},
    {2'b00, 4'h0, 10'h300, 2'b10}, {2'b01, 4'h0, 10'h3ff, 2'b00},
    {2'b00, 4'h7, 10'h3ff, 2'b10}, {2'b10, 4'h0, 10'h100, 2'b10},
    {2'b11, 4'h0, 10'h000, 2'b01}};

  always #25 clk = ~clk;

  vsb_frontend_agc_lock_control #(.EQ_TIMEOUT(50)) dut_u (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sample_clock_in(sclk), .i_sample_in(sdata),
    .o_sample_clock_out(sco), .i_vsb_valid(vsb),
    .i_seg_sync_lock(seg), .i_loops_locked(lkd), .i_sync_err(serr),
    .i_train_valid(tv), .i_train_sym(tsym), .i_eq_sym(esym),
    .o_conv_sample(csamp), .o_conv_valid(cv), .o_symbol_en(se),
    .o_coef_update(cu), .o_carrier_invert(cinv),
    .o_cochannel_filter_bypass(byp), .o_backend_reset(ber),
    .o_eq_reset(eqr), .o_gain_ctrl_out(gout),
    .o_gain_ctrl_oe_n(goe_n), .o_frontend_lock_pin(fel),
    .o_equalizer_lock_pin(eql));

  adc_model adc_u (.i_sclk_fb(sco), .i_gain_out(gout), .i_gain_oe_n(goe_n),
    .i_code(code), .o_sclk(sclk), .o_data(sdata), .o_charge(charge));

  task automatic check(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask
  task automatic wait_st(input logic [1:0] st);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[3:2] !== st && n < 400);
    if (n >= 400) begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic t_reset;
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_THRESH, 32'h0);
    rdc(ADDR_MSE_LIM, {MSE_HI_RST, MSE_LO_RST});
    wr(ADDR_STATUS, 32'h1f);
    rdc(ADDR_STATUS, 32'h20);
    rdc(8'h14, 32'h0);
    `CHK(er, 1'b1);
  endtask
  task automatic t_gain;
    logic [17:0] e;
    int c0;
    for (int i = 0; i < 7; i++) begin
      e = GTAB[i];
      wr(ADDR_CTRL, {29'h0, e[16], 1'b0, e[17]});
      wr(ADDR_THRESH, {28'h0, e[15:12]});
      code <= e[11:2];
      cyc(1100);
      `CHK(goe_n, e[1]);
      c0 = charge;
      cyc(80);
      if (!e[1]) `CHK({gout, charge > c0}, {2{e[0]}});
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[5], e[1]);
    end
  endtask
  task automatic t_len;
    wr(ADDR_THRESH, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    code <= 10'h200;
    cyc(1100);
    wr(ADDR_CTRL, 32'h2);
    code <= 10'h3ff;
    cyc(1100);
    `CHK(!goe_n && gout, 1'b0);
    cyc(4200);
    `CHK({goe_n, gout}, 2'b01);
  endtask
  task automatic t_grst;
    wr(ADDR_CTRL, 32'h8);
    cyc(4);
    `CHK(goe_n, 1'b1);
    cyc(1100);
    `CHK(goe_n, 1'b1);
    wr(ADDR_CTRL, 32'h0);
    cyc(1100);
    `CHK({goe_n, gout}, 2'b01);
  endtask
  task automatic t_bits;
    wr(ADDR_CTRL, 32'h30);
    cyc(2);
    `CHK({cinv, byp}, 2'b11);
    wr(ADDR_CTRL, 32'h10);
    cyc(2);
    `CHK({cinv, byp}, 2'b10);
    wr(ADDR_CTRL, 32'h20);
    cyc(2);
    `CHK({cinv, byp}, 2'b01);
    wr(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_conv;
    int nv, ns;
    nv = 0;
    ns = 0;
    repeat (800) begin
      @(posedge clk);
      nv += int'(cv === 1'b1);
      ns += int'(se === 1'b1);
      if (cv === 1'b1) `CHK(csamp, 10'h1ff);
    end
    `CHK(nv inside {[58:61]}, 1'b1);
    `CHK(ns inside {[28:31]}, 1'b1);
  endtask
  task automatic t_fsm;
    int n;
    vsb <= 1'b1;
    wait_st(2'b01);
    `CHK(ber, 1'b1);
    seg <= 1'b1;
    lkd <= 1'b1;
    tv <= 1'b1;
    cyc(500);
    `CHK(fel, 1'b1);
    rdc(ADDR_STATUS, 32'h15);
    esym <= 8'h40;
    wait_st(2'b10);
    `CHK(ber, 1'b0);
    cyc(1500);
    rdc(ADDR_STATUS, 32'h19);
    apb(1'b0, ADDR_EQ_ERR, 32'h0);
    `CHK(rd inside {[32'h0f00:32'h1000]}, 1'b1);
    esym <= 8'h00;
    wait_st(2'b11);
    rdc(ADDR_STATUS, 32'h1f);
    `CHK({eql, fel}, 2'b11);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      n += int'(cu === 1'b1);
    end
    `CHK(n inside {[6:8]}, 1'b1);
    tsym <= 8'h80;
    esym <= 8'h7f;
    n = 0;
    while (eqr !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      fails++;
      end_of_test();
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[3:2], 2'b11);
    serr <= 1'b1;
    cyc(4);
    `CHK({ber, eql}, 2'b10);
    serr <= 1'b0;
    seg <= 1'b0;
    vsb <= 1'b0;
    cyc(5);
    `CHK(fel, 1'b0);
    wait_st(2'b00);
  endtask

  initial begin
    cyc(8);
    rst_n <= 1'b1;
    t_reset();
    t_gain();
    t_len();
    t_grst();
    t_bits();
    t_conv();
    t_fsm();
    end_of_test();
  end
endmodule // vsb_frontend_agc_lock_control_tb_top
